// *** hdl/cps_pkg.sv ***
// Constants, types and timing counts for the charger power-up sequencer
package cps_pkg;

    // ------------------------------------------------------------
    // Clock rates and dividers
    // ------------------------------------------------------------
    localparam int SYS_KHZ = 100000;
    localparam int SLOW_KHZ = 30;
    localparam int FAST_KHZ = 1500;
    localparam int SLOW_DIV = SYS_KHZ / SLOW_KHZ;
    localparam int FAST_DIV = SYS_KHZ / FAST_KHZ;
    localparam int DIV_W = 12;

    // ------------------------------------------------------------
    // Nominal or least times, in their own units
    // ------------------------------------------------------------
    localparam int T_GATE_DRIVE_REGULATOR_MS = 220;
    localparam int T_BADSRC_MS = 30;
    localparam int T_RETRY_MS = 2000;
    localparam int T_OVP_US = 1;
    localparam int T_RCHG_MS = 20;
    localparam int T_SHIPX_MS = 1250;
    localparam int T_QRST_MS = 12000;
    localparam int T_BRST_MS = 350;
    localparam int T_SMDLY_MS = 10000;

    // ------------------------------------------------------------
    // Tick counts on each digital clock
    // ------------------------------------------------------------
    localparam int CW = 25;
    localparam logic [CW-1:0] GATE_DRIVE_REGULATOR_S = CW'(T_GATE_DRIVE_REGULATOR_MS * SLOW_KHZ);
    localparam logic [CW-1:0] GATE_DRIVE_REGULATOR_F = CW'(T_GATE_DRIVE_REGULATOR_MS * FAST_KHZ);
    localparam logic [CW-1:0] BADSRC_S = CW'(T_BADSRC_MS * SLOW_KHZ);
    localparam logic [CW-1:0] BADSRC_F = CW'(T_BADSRC_MS * FAST_KHZ);
    localparam logic [CW-1:0] RETRY_S = CW'(T_RETRY_MS * SLOW_KHZ);
    localparam logic [CW-1:0] RETRY_F = CW'(T_RETRY_MS * FAST_KHZ);
    localparam logic [CW-1:0] OVP_S = CW'((T_OVP_US * SLOW_KHZ + 999) / 1000);
    localparam logic [CW-1:0] OVP_F = CW'((T_OVP_US * FAST_KHZ + 999) / 1000);
    localparam logic [CW-1:0] RCHG_S = CW'(T_RCHG_MS * SLOW_KHZ);
    localparam logic [CW-1:0] RCHG_F = CW'(T_RCHG_MS * FAST_KHZ);
    localparam logic [CW-1:0] SHIPX_S = CW'(T_SHIPX_MS * SLOW_KHZ);
    localparam logic [CW-1:0] SHIPX_F = CW'(T_SHIPX_MS * FAST_KHZ);
    localparam logic [CW-1:0] QRST_S = CW'(T_QRST_MS * SLOW_KHZ);
    localparam logic [CW-1:0] QRST_F = CW'(T_QRST_MS * FAST_KHZ);
    localparam logic [CW-1:0] BRST_S = CW'(T_BRST_MS * SLOW_KHZ);
    localparam logic [CW-1:0] BRST_F = CW'(T_BRST_MS * FAST_KHZ);
    localparam logic [CW-1:0] SMDLY_S = CW'(T_SMDLY_MS * SLOW_KHZ);
    localparam logic [CW-1:0] SMDLY_F = CW'(T_SMDLY_MS * FAST_KHZ);
    localparam logic [7:0] INT_PULSE_CYC = 8'h10;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam int CTRL_AUTO_DET = 0;
    localparam int CTRL_SHIP_REQ = 1;
    localparam logic [7:0] CTRL_MASK = 8'h03;
    localparam logic [7:0] CTRL_RST = 8'h01;

    typedef enum logic [2:0] {
        ST_HIZ = 3'h0,
        ST_DLY = 3'h1,
        ST_QUAL = 3'h3,
        ST_DET = 3'h2,
        ST_VLIM = 3'h6,
        ST_RUN = 3'h7,
        ST_RETRY = 3'h5
    } cps_state_e;

    typedef struct packed {
        logic vbus_uvlo;
        logic bat_uvlo;
        logic bat_depl;
        logic vbus_sleep;
        logic boost;
        logic vbus_ovp_ok;
        logic vbus_min_ok;
        logic bat_ocp;
        logic bat_ovp;
        logic recharge;
    } cps_sense_s;

    typedef struct packed {
        logic bias_on;
        logic bus_ready;
        logic gate_drive_regulator_en;
        logic high_impedance_state;
        logic test_load;
        logic conv_en;
        logic battery_switch;
        logic fast_clk;
        logic detect_start;
        logic vlim_start;
        logic chg_dis;
        logic recharge_go;
    } cps_ctl_s;

endpackage : cps_pkg

// *** hdl/cps_sequencer.sv ***
// Charger power-up sequencer: bias, start-up order, ship mode, button
// Functional notes
// - Supply release wakes bias, bus, default registers
// - Battery only: close switch, regulator stays off
// - Overcurrent opens switch, sets sticky off flag
// - Source start order: regulator, qualify, detect, limit, converter
// - Detection step only when auto-detect bit set
// - Regulator needs release, sleep margin, 220 ms
// - Any condition false: high impedance, regulator off
// - Qualify: below overvoltage, above minimum under load
// - Pass sets input good flag, interrupt pulse
// - Failed qualification retried every 2 s
// - Test load applied 30 ms per attempt
// - Battery overvoltage 1 us deglitch disables charge
// - Recharge condition deglitched 20 ms
// - Button low 1.25 s exits ship mode
// - Button low 12 s starts full reset
// - Full reset opens switch 350 ms, then recloses
// - Ship entry waits 10 s after request
// - Slow clock regulator off, fast clock on
// - Detection starts only with good input, regulator, enable
// - Interrupt pulse after voltage limit set
`timescale 1ns/1ps
`default_nettype none

module cps_sequencer #(
    parameter int SLOW_DIV = cps_pkg::SLOW_DIV,
    parameter int FAST_DIV = cps_pkg::FAST_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cps_pkg::cps_sense_s sense,
    input wire logic ship_exit_button_n,
    input wire logic detect_done,
    input wire logic vlim_done,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output cps_pkg::cps_ctl_s ctl,
    output logic int_o,
    output logic int_oe_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cps_pkg::cps_state_e st;
        logic [cps_pkg::CW-1:0] seq_cnt;
        logic [cps_pkg::DIV_W-1:0] div_cnt;
        logic tick;
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic [cps_pkg::CW-1:0] btn_cnt;
        logic exit_done;
        logic qrst_done;
        logic [cps_pkg::CW-1:0] ship_cnt;
        logic [cps_pkg::CW-1:0] rst_cnt;
        logic rst_hold;
        logic [cps_pkg::CW-1:0] ovp_cnt;
        logic [cps_pkg::CW-1:0] rchg_cnt;
        logic [7:0] int_cnt;
        logic int_oe_n;
        logic int_lvl;
        cps_pkg::cps_ctl_s ctl;
        logic [7:0] ctrl;
        logic in_good;
        logic bsw_off;
        logic ship_mode;
        logic vbus_prev;
        logic [7:0] rdata;
    } cps_regs_s;

    cps_regs_s r;
    cps_regs_s n;
    cps_pkg::cps_sense_s s;
    logic btn_n_s;
    logic vbus_ok;
    logic fast;

    assign s = r.sync2[9:0];
    assign btn_n_s = r.sync2[10];
    assign fast = r.ctl.fast_clk;
    // Buck needs margin above battery, boost needs it below
    assign vbus_ok = s.vbus_uvlo && (s.boost ? !s.vbus_sleep : s.vbus_sleep);

    function automatic logic [cps_pkg::CW-1:0] pick(
        input logic f,
        input logic [cps_pkg::CW-1:0] a_slow,
        input logic [cps_pkg::CW-1:0] a_fast
    );
        pick = f ? a_fast : a_slow;
    endfunction : pick

    function automatic logic [cps_pkg::CW-1:0] inc(
        input logic [cps_pkg::CW-1:0] c,
        input logic t
    );
        inc = (t && c != {cps_pkg::CW{1'b1}}) ? c + 1'b1 : c;
    endfunction : inc

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [cps_pkg::DIV_W-1:0] div_lim;
        logic int_go;
        logic auto_det;
        n = r;
        div_lim = '0;
        int_go = 1'b0;
        auto_det = r.ctrl[cps_pkg::CTRL_AUTO_DET];

        n.sync1 = {ship_exit_button_n, sense};
        n.sync2 = r.sync1;
        n.int_lvl = 1'b0;

        // Tick of the active digital clock
        div_lim = fast ? cps_pkg::DIV_W'(FAST_DIV - 1)
                       : cps_pkg::DIV_W'(SLOW_DIV - 1);
        n.tick = 1'b0;
        if (r.div_cnt >= div_lim)
        begin
            n.div_cnt = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.div_cnt = r.div_cnt + 1'b1;
        end

        n.ctl.detect_start = 1'b0;
        n.ctl.vlim_start = 1'b0;

        // --------------------------------------------------------
        // Start-up from input source
        // --------------------------------------------------------
        case (r.st)
            cps_pkg::ST_HIZ:
            begin
                n.seq_cnt = '0;
                if (vbus_ok)
                    n.st = cps_pkg::ST_DLY;
            end
            cps_pkg::ST_DLY:
            begin
                n.seq_cnt = inc(r.seq_cnt, r.tick);
                if (r.seq_cnt >= pick(fast, cps_pkg::GATE_DRIVE_REGULATOR_S, cps_pkg::GATE_DRIVE_REGULATOR_F))
                begin
                    n.seq_cnt = '0;
                    n.ctl.gate_drive_regulator_en = 1'b1;
                    n.st = cps_pkg::ST_QUAL;
                end
            end
            cps_pkg::ST_QUAL:
            begin
                n.ctl.test_load = 1'b1;
                n.seq_cnt = inc(r.seq_cnt, r.tick);
                if (r.seq_cnt >= pick(fast, cps_pkg::BADSRC_S,
                                      cps_pkg::BADSRC_F))
                begin
                    n.ctl.test_load = 1'b0;
                    n.seq_cnt = '0;
                    if (s.vbus_ovp_ok && s.vbus_min_ok)
                    begin
                        n.in_good = 1'b1;
                        int_go = 1'b1;
                        // Detection skipped when automatic mode is off
                        n.st = auto_det ? cps_pkg::ST_DET
                                        : cps_pkg::ST_VLIM;
                        n.ctl.detect_start = auto_det;
                        n.ctl.vlim_start = !auto_det;
                    end
                    else
                    begin
                        n.st = cps_pkg::ST_RETRY;
                    end
                end
            end
            cps_pkg::ST_RETRY:
            begin
                n.seq_cnt = inc(r.seq_cnt, r.tick);
                if (r.seq_cnt >= pick(fast, cps_pkg::RETRY_S,
                                      cps_pkg::RETRY_F))
                begin
                    n.seq_cnt = '0;
                    n.st = cps_pkg::ST_QUAL;
                end
            end
            cps_pkg::ST_DET:
            begin
                if (detect_done)
                begin
                    n.ctl.vlim_start = 1'b1;
                    n.st = cps_pkg::ST_VLIM;
                end
            end
            cps_pkg::ST_VLIM:
            begin
                if (vlim_done)
                begin
                    int_go = 1'b1;
                    n.ctl.conv_en = 1'b1;
                    n.st = cps_pkg::ST_RUN;
                end
            end
            cps_pkg::ST_RUN:
            begin
                n.st = cps_pkg::ST_RUN;
            end
            default:
            begin
                n.st = cps_pkg::ST_HIZ;
            end
        endcase

        // Losing any enable condition drops back to high impedance
        if (!vbus_ok)
        begin
            n.st = cps_pkg::ST_HIZ;
            n.seq_cnt = '0;
            n.ctl.gate_drive_regulator_en = 1'b0;
            n.ctl.test_load = 1'b0;
            n.ctl.conv_en = 1'b0;
            n.ctl.detect_start = 1'b0;
            n.ctl.vlim_start = 1'b0;
            n.in_good = 1'b0;
        end
        n.ctl.high_impedance_state = !n.ctl.gate_drive_regulator_en;
        n.ctl.fast_clk = n.ctl.gate_drive_regulator_en;

        // --------------------------------------------------------
        // Push-button hold timing
        // --------------------------------------------------------
        if (!btn_n_s)
        begin
            n.btn_cnt = inc(r.btn_cnt, r.tick);
        end
        else
        begin
            n.btn_cnt = '0;
            n.exit_done = 1'b0;
            n.qrst_done = 1'b0;
        end
        if (!btn_n_s && !r.exit_done &&
            r.btn_cnt >= pick(fast, cps_pkg::SHIPX_S, cps_pkg::SHIPX_F))
        begin
            n.exit_done = 1'b1;
            n.ship_mode = 1'b0;
            n.bsw_off = 1'b0;
        end
        if (!btn_n_s && !r.qrst_done &&
            r.btn_cnt >= pick(fast, cps_pkg::QRST_S, cps_pkg::QRST_F))
        begin
            n.qrst_done = 1'b1;
            n.rst_hold = 1'b1;
            n.rst_cnt = '0;
        end
        else if (r.rst_hold)
        begin
            n.rst_cnt = inc(r.rst_cnt, r.tick);
            if (r.rst_cnt >= pick(fast, cps_pkg::BRST_S, cps_pkg::BRST_F))
                n.rst_hold = 1'b0;
        end

        // --------------------------------------------------------
        // Ship mode entry
        // --------------------------------------------------------
        if (r.ctrl[cps_pkg::CTRL_SHIP_REQ])
        begin
            n.ship_cnt = inc(r.ship_cnt, r.tick);
            if (r.ship_cnt >= pick(fast, cps_pkg::SMDLY_S, cps_pkg::SMDLY_F))
            begin
                n.ship_mode = 1'b1;
                n.ctrl[cps_pkg::CTRL_SHIP_REQ] = 1'b0;
                n.ship_cnt = '0;
            end
        end
        else
        begin
            n.ship_cnt = '0;
        end

        // --------------------------------------------------------
        // Battery switch
        // --------------------------------------------------------
        n.vbus_prev = s.vbus_uvlo;
        if (s.vbus_uvlo && !r.vbus_prev)
            n.bsw_off = 1'b0;
        // Placed after the supply-edge and button clears so a new overcurrent beats them; those clears or loss of both supplies release it later
        if (s.bat_ocp)
            n.bsw_off = 1'b1;
        n.ctl.battery_switch = !n.bsw_off && !n.ship_mode && !n.rst_hold &&
                               !s.bat_ocp &&
                               (s.bat_depl || n.in_good);

        // --------------------------------------------------------
        // Deglitch filters
        // --------------------------------------------------------
        if (s.bat_ovp)
        begin
            n.ovp_cnt = inc(r.ovp_cnt, r.tick);
            if (r.ovp_cnt >= pick(fast, cps_pkg::OVP_S, cps_pkg::OVP_F))
                n.ctl.chg_dis = 1'b1;
        end
        else
        begin
            n.ovp_cnt = '0;
            n.ctl.chg_dis = 1'b0;
        end
        if (s.recharge)
        begin
            n.rchg_cnt = inc(r.rchg_cnt, r.tick);
            if (r.rchg_cnt >= pick(fast, cps_pkg::RCHG_S, cps_pkg::RCHG_F))
                n.ctl.recharge_go = 1'b1;
        end
        else
        begin
            n.rchg_cnt = '0;
            n.ctl.recharge_go = 1'b0;
        end

        // --------------------------------------------------------
        // Interrupt pulse
        // --------------------------------------------------------
        if (int_go)
        begin
            n.int_cnt = cps_pkg::INT_PULSE_CYC;
            n.int_oe_n = 1'b0;
        end
        else if (r.int_cnt > 8'h01)
        begin
            n.int_cnt = r.int_cnt - 1'b1;
        end
        else
        begin
            n.int_cnt = '0;
            n.int_oe_n = 1'b1;
        end

        // --------------------------------------------------------
        // Register port
        // --------------------------------------------------------
        n.rdata = '0;
        if (r.ctl.bus_ready && reg_wr && reg_addr == cps_pkg::ADDR_CTRL)
            n.ctrl = reg_wdata & cps_pkg::CTRL_MASK;
        if (r.ctl.bus_ready && reg_rd)
        begin
            case (reg_addr)
                cps_pkg::ADDR_CTRL:
                    n.rdata = r.ctrl;
                cps_pkg::ADDR_STATUS:
                    n.rdata = {r.ctl.recharge_go, r.ctl.chg_dis, r.ship_mode,
                               r.ctl.conv_en, r.ctl.high_impedance_state,
                               r.ctl.gate_drive_regulator_en, r.bsw_off, r.in_good};
                default:
                    n.rdata = '0;
            endcase
        end

        // Without either supply the core rests in its default state
        n.ctl.bias_on = s.vbus_uvlo || s.bat_uvlo;
        n.ctl.bus_ready = n.ctl.bias_on;
        if (!n.ctl.bias_on)
        begin
            n.st = cps_pkg::ST_HIZ;
            n.seq_cnt = '0;
            n.ctrl = cps_pkg::CTRL_RST;
            n.in_good = 1'b0;
            n.bsw_off = 1'b0;
            n.ship_mode = 1'b0;
            n.rst_hold = 1'b0;
            n.ship_cnt = '0;
            n.ctl.gate_drive_regulator_en = 1'b0;
            n.ctl.high_impedance_state = 1'b1;
            n.ctl.fast_clk = 1'b0;
            n.ctl.test_load = 1'b0;
            n.ctl.conv_en = 1'b0;
            n.ctl.battery_switch = 1'b0;
            n.ctl.detect_start = 1'b0;
            n.ctl.vlim_start = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.int_oe_n <= 1'b1;
            r.ctrl <= cps_pkg::CTRL_RST;
            r.ctl.high_impedance_state <= 1'b1;
            r.sync1 <= 11'h400;
            r.sync2 <= 11'h400;
        end
        else
        begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign ctl = r.ctl;
    assign int_o = r.int_lvl;
    assign int_oe_n = r.int_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence int_low_s;
        !int_oe_n [*8];
    endsequence

    por_default_a: assert property (
        !s.vbus_uvlo && !s.bat_uvlo |=> r.ctrl == cps_pkg::CTRL_RST &&
        !ctl.gate_drive_regulator_en && !ctl.bias_on)
        else $error("registers not at default without supply");

    ocp_open_a: assert property (
        (s.vbus_uvlo || s.bat_uvlo) && s.bat_ocp |=>
        !ctl.battery_switch && r.bsw_off)
        else $error("overcurrent did not open battery switch");

    hiz_drop_a: assert property (
        !vbus_ok |=> !ctl.gate_drive_regulator_en && ctl.high_impedance_state)
        else $error("regulator on while enable condition false");

    load_len_a: assert property (
        $rose(ctl.test_load) |-> ctl.test_load [*8])
        else $error("test load dropped early");

    int_pulse_a: assert property (
        $fell(int_oe_n) |-> int_low_s ##9 int_oe_n && !int_o)
        else $error("interrupt pulse length wrong");

    qual_int_a: assert property (
        $rose(r.in_good) |-> !int_oe_n)
        else $error("input good set without interrupt");

    det_gate_a: assert property (
        ctl.detect_start |-> r.in_good && ctl.gate_drive_regulator_en &&
        r.ctrl[cps_pkg::CTRL_AUTO_DET])
        else $error("detection started without its conditions");

    conv_order_a: assert property (
        $rose(ctl.conv_en) |-> $past(r.st) == cps_pkg::ST_VLIM &&
        r.in_good && !int_oe_n)
        else $error("converter started out of order");

    reset_open_a: assert property (
        $rose(r.rst_hold) |-> !ctl.battery_switch ##1 !ctl.battery_switch)
        else $error("switch closed during full reset");

    clk_sel_a: assert property (
        ctl.fast_clk == ctl.gate_drive_regulator_en)
        else $error("clock selection not tied to regulator");

endmodule : cps_sequencer

`default_nettype wire

// *** tb/cps_detector_model.sv ***
// Behavioural source detector and voltage-limit setter
`timescale 1ns/1ps
`default_nettype none

module cps_detector_model (
    input wire logic sys_clk,
    input wire logic detect_start,
    input wire logic vlim_start,
    output logic detect_done,
    output logic vlim_done
);
    // ------------------------------------------------------------
    // Late one-cycle answers
    // ------------------------------------------------------------
    int dcnt = 0;
    int vcnt = 0;
    initial detect_done = 1'b0;
    initial vlim_done = 1'b0;
    // Slow answer keeps the two interrupt pulses apart
    always @(posedge sys_clk)
    begin
        detect_done <= (dcnt == 1);
        vlim_done <= (vcnt == 1);
        dcnt <= detect_start ? 9 : (dcnt > 0 ? dcnt - 1 : 0);
        vcnt <= vlim_start ? 9 : (vcnt > 0 ? vcnt - 1 : 0);
    end
endmodule : cps_detector_model

`default_nettype wire

// *** tb/charger_power_up_sequencer_test.sv ***
// Self-checking bench of the charger power-up sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
    failures++; $display("BAD %s exp %h got %h", nm, e, a); end end

module charger_power_up_sequencer_test;
    // ------------------------------------------------------------
    // Signals, clock, partner
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    cps_pkg::cps_sense_s sense = '0;
    logic ship_exit_button_n = 1'b1;
    logic detect_done;
    logic vlim_done;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] d;
    cps_pkg::cps_ctl_s ctl;
    logic int_o;
    logic int_oe_n;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    logic seen_det = 1'b0;
    initial forever #5 sys_clk = ~sys_clk;

    cps_sequencer #(.SLOW_DIV(1), .FAST_DIV(1)) cps_sequencer_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .sense(sense),
        .ship_exit_button_n(ship_exit_button_n),
        .detect_done(detect_done), .vlim_done(vlim_done),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl(ctl),
        .int_o(int_o), .int_oe_n(int_oe_n));
    cps_detector_model cps_detector_model_inst (
        .sys_clk(sys_clk), .detect_start(ctl.detect_start),
        .vlim_start(ctl.vlim_start), .detect_done(detect_done),
        .vlim_done(vlim_done));

    always @(posedge sys_clk)
    begin
        if (ctl.detect_start === 1'b1)
            seen_det <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 100000)
        begin
            failures++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_battery_only();
        @(posedge sys_clk);
        sense.bat_uvlo <= 1'b1;
        sense.bat_depl <= 1'b1;
        cyc(8);
        `CHK("bias_on", 1'b1, ctl.bias_on)
        `CHK("bus_ready", 1'b1, ctl.bus_ready)
        `CHK("switch", 1'b1, ctl.battery_switch)
        `CHK("gate_drive_regulator", 1'b0, ctl.gate_drive_regulator_en)
        `CHK("int_o", 1'b0, int_o)
        `CHK("int_idle", 1'b1, int_oe_n)
        rd(4'h0);
        `CHK("ctrl_rst", 8'h01, d)
        rd(4'h5);
        `CHK("unmapped", 8'h00, d)
        wr(4'h0, 8'hFC);
        rd(4'h0);
        `CHK("ctrl_wr", 8'h00, d)
        wr(4'h0, 8'h01);
    endtask : t_battery_only

    task automatic t_overcurrent();
        @(posedge sys_clk);
        sense.bat_ocp <= 1'b1;
        cyc(5);
        `CHK("ocp_sw", 1'b0, ctl.battery_switch)
        sense.bat_ocp <= 1'b0;
        cyc(8);
        `CHK("ocp_hold", 1'b0, ctl.battery_switch)
        rd(4'h1);
        `CHK("off_flag", 1'b1, d[1])
    endtask : t_overcurrent

    task automatic t_button();
        @(posedge sys_clk);
        ship_exit_button_n <= 1'b0;
        cyc(4000);
        ship_exit_button_n <= 1'b1;
        cyc(8);
        rd(4'h1);
        `CHK("short_press", 1'b1, d[1])
        ship_exit_button_n <= 1'b0;
        // Release cleared the count, so this press alone must exceed the exit time
        cyc(34000);
        rd(4'h1);
        `CHK("hold_clear", 1'b1, d[1])
        cyc(3700);
        ship_exit_button_n <= 1'b1;
        cyc(8);
        rd(4'h1);
        `CHK("exit_flag", 1'b0, d[1])
        `CHK("exit_sw", 1'b1, ctl.battery_switch)
    endtask : t_button

    task automatic t_source();
        @(posedge sys_clk);
        sense.vbus_uvlo <= 1'b1;
        sense.vbus_sleep <= 1'b1;
        sense.vbus_ovp_ok <= 1'b1;
        sense.vbus_min_ok <= 1'b1;
        n = 0;
        do begin cyc(1); n++; end while (ctl.gate_drive_regulator_en !== 1'b1 && n < 7000);
        `CHK("gate_drive_regulator_dly", 1'b1, n >= 6595 && n <= 6610)
        `CHK("fast_clk", 1'b1, ctl.fast_clk)
        `CHK("hiz_off", 1'b0, ctl.high_impedance_state)
        cyc(1);
        `CHK("load_on", 1'b1, ctl.test_load)
        n = 0;
        do begin cyc(1); n++; end while (ctl.test_load === 1'b1 && n < 46000);
        `CHK("load_len", 1'b1, n >= 44995 && n <= 45005)
        `CHK("det_early", 1'b0, seen_det)
        n = 0;
        while (int_oe_n === 1'b0 && n < 40)
        begin
            n++;
            cyc(1);
        end
        `CHK("int_len", 1'b1, n == 16)
        `CHK("det_run", 1'b1, seen_det)
        n = 0;
        while (ctl.conv_en !== 1'b1 && n < 100)
        begin
            n++;
            cyc(1);
        end
        `CHK("conv_int", 1'b0, int_oe_n)
        `CHK("conv_en", 1'b1, ctl.conv_en)
        rd(4'h1);
        `CHK("status", 8'h15, d)
    endtask : t_source

    task automatic t_source_loss();
        @(posedge sys_clk);
        sense.vbus_uvlo <= 1'b0;
        cyc(6);
        `CHK("loss_gate_drive_regulator", 1'b0, ctl.gate_drive_regulator_en)
        `CHK("loss_hiz", 1'b1, ctl.high_impedance_state)
        `CHK("loss_conv", 1'b0, ctl.conv_en)
        `CHK("slow_clk", 1'b0, ctl.fast_clk)
    endtask : t_source_loss

    task automatic t_deglitch();
        @(posedge sys_clk);
        sense.bat_ovp <= 1'b1;
        sense.recharge <= 1'b1;
        cyc(3);
        `CHK("ovp_early", 1'b0, ctl.chg_dis)
        cyc(2);
        `CHK("ovp_dis", 1'b1, ctl.chg_dis)
        // Recharge waits 600 slow ticks
        cyc(590);
        `CHK("rchg_early", 1'b0, ctl.recharge_go)
        cyc(15);
        `CHK("rchg_go", 1'b1, ctl.recharge_go)
        sense.bat_ovp <= 1'b0;
        sense.recharge <= 1'b0;
        cyc(4);
        `CHK("ovp_clr", 1'b0, ctl.chg_dis)
        `CHK("rchg_clr", 1'b0, ctl.recharge_go)
    endtask : t_deglitch

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_battery_only();
        t_overcurrent();
        t_button();
        t_source();
        t_source_loss();
        t_deglitch();
        results();
    end
endmodule : charger_power_up_sequencer_test

`default_nettype wire
